// ==== general_timer_set.sv ====
// standalone 16-bit timer plus pairs of 16-bit timers that can join into 32 bits,
// with a classic wishbone slave for all registers.
// assumes clk_i is the instruction clock; pins are asynchronous and are synchronised here.
//
// Overview of operation
// - standalone counts only while timer_on set
// - prescale codes divide by 1, 8, 64, 256
// - clock source: pin rising edge or instruction clock
// - gate counts only with internal clock selected
// - sync bit matters only with external clock
// - idle_stop halts timer during idle
// - flag on period match or gate falling edge
// - standalone: timer, sync counter, async counter
// - async standalone keeps counting during sleep
// - join bit merges pair into 32 bits
// - upper count holds high word
// - upper period holds high period word
// - joined pair obeys lower control and pin
// - joined match uses upper flag and enable
// - split pair timers run independently, synchronous
// - joined interrupt on full 32-bit match
// - only first pair drives converter trigger
// - only first pair timers request transfers
// - first pair counts exported as time bases
// - lower timer_on starts whole joined pair
`timescale 1ns/1ps
module general_timer_set #(
    parameter int NUM_PAIRS = 4                        // number of joinable timer pairs
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [general_timer_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [general_timer_pkg::DATA_W-1:0] wb_dat_i,
    output logic [general_timer_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // device power state
    input wire logic idle_i,
    input wire logic sleep_i,
    // external clock and gate pins
    input wire logic standalone_ext_clock_pin_i,
    input wire logic [2*NUM_PAIRS-1:0] pair_ext_clock_pin_i,
    // interrupt requests, one per timer slot
    output logic [2*NUM_PAIRS:0] irq_o,
    // first pair consumers
    output logic adc_trigger_o,
    output logic [1:0] dma_req_o,
    output logic [15:0] lower_time_base_o,
    output logic [15:0] upper_time_base_o
);
    import general_timer_pkg::*;

    localparam int NT = 2*NUM_PAIRS+1;                 // slot 0 standalone, odd lower, even upper

    // ************************************************************
    // parameter check
    // ************************************************************
    if (NUM_PAIRS < 1 || NUM_PAIRS > MAX_PAIRS) begin : g_bad_pairs
        $error("NUM_PAIRS must lie between 1 and 7");
    end

    // ************************************************************
    // state
    // ************************************************************
    logic [15:0] ctrl [NT];                            // control registers
    logic [15:0] count [NT];                           // count registers
    logic [15:0] period [NT];                          // period registers
    logic [7:0] pre [NT];                              // prescaler counters
    logic [15:0] next_count [NT];                      // next count values
    logic [7:0] next_pre [NT];                         // next prescaler values
    logic [NT-1:0] flag;                               // sticky interrupt flags
    logic [NT-1:0] irq_en;                             // interrupt enables
    logic [NT-1:0] sync1, sync2, sync3;                // pin synchroniser stages
    logic [NT-1:0] lvl;                                // filtered pin level
    logic [NT-1:0] lvl_d;                              // filtered level, one cycle late
    logic ack;                                         // bus acknowledge
    wire [NT-1:0] pin_raw = {pair_ext_clock_pin_i, standalone_ext_clock_pin_i};
    wire [NT-1:0] rise = lvl & ~lvl_d;                 // pin rising edge
    wire [NT-1:0] fall = ~lvl & lvl_d;                 // pin falling edge
    wire [NT-1:0] tick;                                // count step per slot
    wire [NT-1:0] hit;                                 // period match on a step
    wire [NT-1:0] set_ev;                              // flag set events
    wire [NT-1:0] m32;                                 // 32-bit match, valid on lower slots
    wire [NT-1:0] lower_joined;                        // slot is lower half of joined pair
    wire [NT-1:0] upper_joined;                        // slot is upper half of joined pair

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // three stages; the level moves only when stages two and three agree,
    // which rejects a single-cycle glitch at the cost of one more cycle of latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            lvl <= '0;
            lvl_d <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            lvl <= (sync2 & sync3) | (lvl & (sync2 ^ sync3));
            lvl_d <= lvl;
        end
    end

    // ************************************************************
    // wishbone decode
    // ************************************************************
    wire bus_req = wb_cyc_i & wb_stb_i;                // request present
    wire wr_stb = bus_req & wb_we_i & ack;             // write lands on the ack edge
    wire [3:0] tsel = wb_adr_i[7:4];                   // timer slot
    wire [1:0] rsel = wb_adr_i[3:2];                   // register within slot
    wire tsel_ok = (tsel < 4'(NT)) && (wb_adr_i[1:0] == 2'h0);
    wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire flag_wr = wr_stb && (wb_adr_i == FLAG_ADDR);
    wire en_wr = wr_stb && (wb_adr_i == ENABLE_ADDR);
    wire [NT-1:0] flag_clr = flag_wr ? wb_dat_i[NT-1:0] : '0;
    wire [15:0] rd_timer = !tsel_ok ? 16'h0000 :
                           (rsel == REG_CTRL) ? ctrl[tsel] :
                           (rsel == REG_COUNT) ? count[tsel] :
                           (rsel == REG_PERIOD) ? period[tsel] : 16'h0000;
    wire [31:0] rd_word = (wb_adr_i == FLAG_ADDR) ? {{(32-NT){1'b0}}, flag} :
                          (wb_adr_i == ENABLE_ADDR) ? {{(32-NT){1'b0}}, irq_en} :
                          {16'h0000, rd_timer};

    // merge byte lanes of a write into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    // terminal prescaler count for a prescale_select code
    function automatic logic [7:0] ps_last(input logic [1:0] code);
        case (code)
            2'b11: ps_last = PS_LAST_256;
            2'b10: ps_last = PS_LAST_64;
            2'b01: ps_last = PS_LAST_8;
            default: ps_last = PS_LAST_1;
        endcase
    endfunction : ps_last

    // implemented control bits for a slot
    function automatic logic [15:0] ctrl_mask(input int k);
        if (k == 0) begin
            ctrl_mask = STANDALONE_MASK;
        end else if (k % 2 == 1) begin
            ctrl_mask = LOWER_MASK;
        end else begin
            ctrl_mask = UPPER_MASK;
        end
    endfunction : ctrl_mask

    // ************************************************************
    // bus answer
    // ************************************************************
    // one wait state: ack rises the cycle after the request, drops after one cycle;
    // unmapped addresses are acknowledged and read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack <= bus_req & ~ack;
            if (bus_req & ~ack) begin
                wb_dat_o <= rd_word;
            end
        end
    end
    assign wb_ack_o = ack;

    // ************************************************************
    // software-only registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < NT; k++) begin
                ctrl[k] <= CTRL_RESET;
                period[k] <= PERIOD_RESET;
            end
            irq_en <= '0;
        end else begin
            for (int k = 0; k < NT; k++) begin
                if (wr_stb && tsel_ok && tsel == 4'(k) && rsel == REG_CTRL) begin
                    ctrl[k] <= merge(ctrl[k], wb_dat_i[15:0], wmask) & ctrl_mask(k);
                end
                if (wr_stb && tsel_ok && tsel == 4'(k) && rsel == REG_PERIOD) begin
                    period[k] <= merge(period[k], wb_dat_i[15:0], wmask);
                end
            end
            if (en_wr) begin
                irq_en <= wb_dat_i[NT-1:0];
            end
        end
    end

    // ************************************************************
    // per-slot timer logic
    // ************************************************************
    for (genvar i = 0; i < NT; i++) begin : g_timer
        // upper half of a pair takes its controls and pin from the lower half when joined
        localparam int LO = (i > 0 && i % 2 == 0) ? i-1 : i;
        wire jn_up = (i > 0 && i % 2 == 0) ? ctrl[LO][JOIN_BIT] : 1'b0;
        wire jn_lo = (i % 2 == 1) ? ctrl[i][JOIN_BIT] : 1'b0;
        wire [15:0] ec = jn_up ? ctrl[LO] : ctrl[i];
        wire lv = jn_up ? lvl[LO] : lvl[i];
        wire rs = jn_up ? rise[LO] : rise[i];
        wire fl = jn_up ? fall[LO] : fall[i];
        wire clock_source_select = ec[TCS_BIT];
        wire gated = ec[GATE_BIT] & ~clock_source_select;
        // only the standalone slot offers unsynchronised counting
        wire asyn = (i == 0) ? (clock_source_select & ~ec[SYNC_BIT]) : 1'b0;
        // sleep stops the instruction clock; only the async counter survives it
        wire run = ec[TIMER_ON_BIT] & ~(idle_i & ec[IDLE_STOP_BIT])
                   & ~(sleep_i & ~asyn);
        wire src_tick = clock_source_select ? rs : (~gated | lv);
        wire [7:0] last = ps_last(ec[PS_HI_BIT:PS_LO_BIT]);
        wire pre_hit = run & src_tick & (pre[i] == last);
        wire m16 = (count[i] == period[i]);

        assign lower_joined[i] = jn_lo;
        assign upper_joined[i] = jn_up;
        assign next_pre[i] = !run ? 8'h00 :
                             !src_tick ? pre[i] :
                             (pre[i] == last) ? 8'h00 : pre[i] + 8'h01;
        // only an upper slot may borrow its step; a self-select here would form a loop
        if (i > 0 && i % 2 == 0) begin : g_up_tick
            assign tick[i] = jn_up ? tick[LO] : pre_hit;
        end else begin : g_own_tick
            assign tick[i] = pre_hit;
        end

        if (i % 2 == 1) begin : g_lower
            // upper period and count form the high word of the 32-bit compare
            assign m32[i] = ({count[i+1], count[i]} == {period[i+1], period[i]});
        end else begin : g_other
            assign m32[i] = 1'b0;
        end

        wire mt = (jn_lo || jn_up) ? m32[LO] : m16;
        wire step = jn_up ? (count[LO] == COUNT_MAX) : 1'b1;
        assign hit[i] = tick[i] & mt;
        assign next_count[i] = !tick[i] ? count[i] :
                               mt ? COUNT_RESET :
                               step ? count[i] + 16'h0001 : count[i];
        // lower half of a joined pair never flags; the upper slot does it
        assign set_ev[i] = ~jn_lo & (hit[i] | (gated & run & fl));
    end

    // ************************************************************
    // counters, prescalers and flags
    // ************************************************************
    // a bus write to a count wins over counting; a flag set wins over its clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < NT; k++) begin
                count[k] <= COUNT_RESET;
                pre[k] <= 8'h00;
            end
            flag <= '0;
        end else begin
            for (int k = 0; k < NT; k++) begin
                pre[k] <= next_pre[k];
                if (wr_stb && tsel_ok && tsel == 4'(k) && rsel == REG_COUNT) begin
                    count[k] <= merge(count[k], wb_dat_i[15:0], wmask);
                end else begin
                    count[k] <= next_count[k];
                end
            end
            flag <= (flag & ~flag_clr) | set_ev;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // converter trigger and transfer requests exist on the first pair only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_trigger_o <= 1'b0;
            dma_req_o <= 2'b00;
        end else begin
            adc_trigger_o <= set_ev[2];
            dma_req_o <= set_ev[2:1];
        end
    end
    assign irq_o = flag & irq_en;
    assign lower_time_base_o = count[1];
    assign upper_time_base_o = count[2];

    // ************************************************************
    // assertions
    // ************************************************************
    wire cnt0_wr = wr_stb && tsel == 4'h0 && rsel == REG_COUNT;
    wire cnt_pair_wr = wr_stb && (tsel == 4'h1 || tsel == 4'h2) && rsel == REG_COUNT;

    sequence s_match0;
        tick[0] && (count[0] == period[0]) && !cnt0_wr;
    endsequence
    sequence s_cleared0;
        (count[0] == COUNT_RESET) && flag[0];
    endsequence

    a_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl[0][TIMER_ON_BIT] && !cnt0_wr) |=> (count[0] == $past(count[0])))
        else $error("standalone count moved while off");
    a_prescale_div: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick[0] && ctrl[0][PS_HI_BIT:PS_LO_BIT] == 2'b01) |-> (pre[0] == PS_LAST_8))
        else $error("prescaler step at wrong count");
    a_ext_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick[0] && ctrl[0][TCS_BIT]) |-> rise[0])
        else $error("external step without pin edge");
    a_gate_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl[0][GATE_BIT] && !ctrl[0][TCS_BIT] && !lvl[0]) |-> !tick[0])
        else $error("gated timer stepped with gate low");
    a_idle_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_i && ctrl[0][IDLE_STOP_BIT]) |-> (!tick[0] ##1 pre[0] == 8'h00))
        else $error("timer ran in idle with idle_stop");
    a_match_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        s_match0 |=> s_cleared0)
        else $error("period match did not clear and flag");
    a_async_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
        (sleep_i && ctrl[0][TIMER_ON_BIT] && ctrl[0][TCS_BIT] && !ctrl[0][SYNC_BIT]
         && !ctrl[0][IDLE_STOP_BIT] && rise[0] && pre[0] == ps_last(ctrl[0][5:4]))
        |-> tick[0])
        else $error("async counter stalled in sleep");
    a_join_carry: assert property (@(posedge clk_i) disable iff (rst_i)
        (lower_joined[1] && tick[1] && count[1] == COUNT_MAX && !m32[1] && !cnt_pair_wr)
        |=> (count[1] == 16'h0000 && count[2] == $past(count[2]) + 16'h0001))
        else $error("joined pair missed carry");
    a_join_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (lower_joined[1] && hit[1]) |=> (flag[2] && flag[1] == $past(flag[1] & ~flag_clr[1])))
        else $error("joined match flagged wrong slot");
    a_trigger_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        set_ev[2] |=> (adc_trigger_o && dma_req_o[1]))
        else $error("first pair event not exported");

endmodule : general_timer_set

// ==== general_timer_pkg.sv ====
// constants shared by the general timer set: register map, field positions,
// reset values and prescaler terminal counts.
// assumes a 32-bit classic wishbone master with byte addresses.
package general_timer_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 8;                 // byte address width
    localparam int DATA_W = 32;                // bus data width
    localparam int MAX_PAIRS = 7;              // timer slots 0..14 fit below the flag block

    // ************************************************************
    // register map: timer k occupies bytes k*16 .. k*16+11
    // ************************************************************
    localparam logic [1:0] REG_CTRL = 2'h0;    // word index of a control register
    localparam logic [1:0] REG_COUNT = 2'h1;   // word index of a count register
    localparam logic [1:0] REG_PERIOD = 2'h2;  // word index of a period register
    localparam logic [7:0] FLAG_ADDR = 8'hf0;  // interrupt flags, write one to clear
    localparam logic [7:0] ENABLE_ADDR = 8'hf4; // interrupt enables

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int TIMER_ON_BIT = 15;          // timer_on
    localparam int IDLE_STOP_BIT = 13;         // idle_stop
    localparam int GATE_BIT = 6;               // gate_accumulate_enable
    localparam int PS_HI_BIT = 5;              // prescale_select msb
    localparam int PS_LO_BIT = 4;              // prescale_select lsb
    localparam int JOIN_BIT = 3;               // pair_join_mode, lower timer only
    localparam int SYNC_BIT = 2;               // external_clock_sync, standalone only
    localparam int TCS_BIT = 1;                // clock_source_select

    // implemented bits per control register kind, the rest read as zero
    localparam logic [15:0] STANDALONE_MASK = 16'ha076;
    localparam logic [15:0] LOWER_MASK = 16'ha07a;
    localparam logic [15:0] UPPER_MASK = 16'ha072;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;

    // ************************************************************
    // prescaler terminal counts (divide minus one)
    // ************************************************************
    localparam logic [7:0] PS_LAST_1 = 8'h00;
    localparam logic [7:0] PS_LAST_8 = 8'h07;
    localparam logic [7:0] PS_LAST_64 = 8'h3f;
    localparam logic [7:0] PS_LAST_256 = 8'hff;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

endpackage : general_timer_pkg

// ==== pin_source.sv ====
// behavioural source for the timer clock and gate pins.
// assumes start_i is a one-cycle pulse from the bench that opens one burst.
`timescale 1ns/1ps
module pin_source (
    // clock and burst control
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [7:0] pulses_i,
    input wire logic [7:0] half_i,
    // pin towards the timers
    output logic pin_o
);
    // ****
    // burst generator
    // ****
    int left = 0;  // half periods still to send
    int tick = 0;  // cycles spent in this half period
    initial pin_o = 1'b0;
    // the pin stands low between bursts, so no stray edge reaches a timer
    always @(posedge clk_i) begin
        if (start_i) begin
            left <= 2 * pulses_i;
            tick <= 0;
        end else if (left != 0) begin
            // each toggle ends one half period
            if (tick == half_i - 1) begin
                tick <= 0;
                left <= left - 1;
                pin_o <= ~pin_o;
            end else begin
                tick <= tick + 1;
            end
        end
    end
endmodule : pin_source

// ==== general_timer_set_tb.sv ====
// self-checking bench for the general timer set: registers, counting, pins.
// assumes the design acks every bus cycle and the pin source drives all pins.
`timescale 1ns/1ps
module general_timer_set_tb;
    import general_timer_pkg::*;
    // ****
    // stimulus and observed signals
    // ****
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic start = 1'b0;
    logic [7:0] pulses = 8'h00;
    logic [7:0] half = 8'h01;
    logic pin;
    logic [31:0] rdat;
    logic ack;
    logic [8:0] irq;
    logic adc;
    logic [1:0] dma;
    logic [15:0] tb_lo;
    logic [15:0] tb_hi;
    logic adc_seen = 1'b0;  // sticky converter trigger
    logic [1:0] dma_seen = 2'b00;  // sticky transfer requests
    logic [31:0] rd_val;  // data of the last bus read
    int fail_count = 0;
    int compares = 0;
    int div;
    always #5 clk_i = ~clk_i;
    general_timer_set #(.NUM_PAIRS(4)) general_timer_set_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .idle_i(idle), .sleep_i(sleep),
        .standalone_ext_clock_pin_i(pin), .pair_ext_clock_pin_i({8{pin}}), .irq_o(irq),
        .adc_trigger_o(adc), .dma_req_o(dma), .lower_time_base_o(tb_lo),
        .upper_time_base_o(tb_hi));
    pin_source pin_source_i (.clk_i(clk_i), .start_i(start), .pulses_i(pulses),
        .half_i(half), .pin_o(pin));
    // pulses last one cycle, so remember them until the checks look
    always @(posedge clk_i) begin
        if (adc === 1'b1) adc_seen <= 1'b1;
        // the request flops are unknown before the first reset edge
        if (!rst_i) dma_seen <= dma_seen | dma;
    end
    // ****
    // bus, pin and compare tasks
    // ****
    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd_val = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic fire(input logic [7:0] n, input logic [7:0] h);
        start <= 1'b1;
        pulses <= n;
        half <= h;
        @(posedge clk_i);
        start <= 1'b0;
    endtask : fire
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // counts that depend on a few cycles of bus latency are checked in a window
    task automatic rng(input string n, input int lo, input int hi, input logic [31:0] g);
        compares++;
        if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1)) begin
            fail_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", n, lo, hi, g);
        end
    endtask : rng
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd_val);
    endtask : rdc
    task automatic end_sim;
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    // the whole sequence needs about 7500 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end
    // ****
    // test sequence
    // ****
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("period reset", 8'h08, {16'h0, PERIOD_RESET});
        bus(1'b1, 8'h00, 32'hffff);
        rdc("standalone bits", 8'h00, {16'h0, STANDALONE_MASK});
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h10, 32'hffff);
        rdc("lower bits", 8'h10, {16'h0, LOWER_MASK});
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'hc0, 32'hffff);
        rdc("unmapped", 8'hc0, 32'h0);
        bus(1'b1, 8'h08, 32'hffff);
        // every prescale code gives twenty steps in twenty divided periods
        for (int c = 0; c < 4; c++) begin
            div = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
            bus(1'b1, 8'h04, 32'h0);
            bus(1'b1, 8'h00, 32'h8000 | (c << 4));
            repeat (div * 20 - 3) @(posedge clk_i);
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b0, 8'h04, 32'h0);
            rng("prescaled count", 19, 21, rd_val);
            repeat (50) @(posedge clk_i);
            rdc("stopped count", 8'h04, rd_val);
        end
        // pin edges: synchronised, unsynchronised in sleep, synchronised in sleep
        for (int s = 0; s < 3; s++) begin
            sleep <= (s != 0);
            bus(1'b1, 8'h04, 32'h0);
            bus(1'b1, 8'h00, (s == 1) ? 32'h8042 : 32'h8046);
            bus(1'b1, 8'h14, 32'h0);
            bus(1'b1, 8'h10, 32'h8002);
            fire(8'd10, 8'd3);
            repeat (80) @(posedge clk_i);
            rdc("pin edges", 8'h04, (s == 2) ? 32'd0 : 32'd10);
            rdc("pair pin edges", 8'h14, (s == 0) ? 32'd10 : 32'd0);
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b1, 8'h10, 32'h0);
        end
        sleep <= 1'b0;
        // gated accumulation counts the high time and flags the falling edge
        bus(1'b1, FLAG_ADDR, 32'h1ff);
        bus(1'b1, ENABLE_ADDR, 32'h1ff);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h8040);
        fire(8'd1, 8'd40);
        // the pin stays low for one half period, then high for one, then falls
        repeat (100) @(posedge clk_i);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        rng("gated count", 38, 42, rd_val);
        rdc("gate flag", FLAG_ADDR, 32'h1);
        // period match wraps the count and raises the interrupt
        bus(1'b1, FLAG_ADDR, 32'h1ff);
        bus(1'b1, 8'h08, 32'h5);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h8000);
        repeat (12) @(posedge clk_i);
        chk("match irq", 32'h1, 32'(irq[0]));
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        rng("wrapped count", 0, 5, rd_val);
        // idle halts only a timer with idle_stop set
        idle <= 1'b1;
        bus(1'b1, 8'h08, 32'hffff);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'ha000);
        repeat (20) @(posedge clk_i);
        rdc("idle halted", 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h8000);
        repeat (20) @(posedge clk_i);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        rng("idle running", 18, 26, rd_val);
        idle <= 1'b0;
        // joined pair: rollover into the upper word, 32-bit match, upper flag
        bus(1'b1, FLAG_ADDR, 32'h1ff);
        bus(1'b1, 8'h14, 32'hfffd);
        bus(1'b1, 8'h24, 32'h0);
        bus(1'b1, 8'h18, 32'h2);
        bus(1'b1, 8'h28, 32'h1);
        bus(1'b1, 8'h20, 32'h0030);
        bus(1'b1, 8'h10, 32'h8008);
        repeat (20) @(posedge clk_i);
        bus(1'b1, 8'h10, 32'h0008);
        rdc("joined flags", FLAG_ADDR, 32'h4);
        rdc("upper cleared", 8'h24, 32'h0);
        bus(1'b0, 8'h14, 32'h0);
        rng("lower after match", 14, 20, rd_val);
        chk("upper irq", 32'h1, 32'(irq[2]));
        chk("converter trigger", 32'h1, 32'(adc_seen));
        chk("transfer requests", 32'h2, 32'(dma_seen));
        bus(1'b1, 8'h14, 32'h1234);
        bus(1'b1, 8'h24, 32'h0042);
        @(posedge clk_i);
        chk("lower time base", 32'h1234, 32'(tb_lo));
        chk("upper time base", 32'h0042, 32'(tb_hi));
        end_sim();
    end
endmodule : general_timer_set_tb
